/* File: hdl/flash_led_config.sv */
/*
 * Configuration and control register bank of a dual flash LED driver with
 * the digital sequencing it steers: flash triggering, per-LED timing,
 * time-outs, torch and indicator enables, charge pump control, LED checks
 * and the thermal latch. Assumes the serial port decodes into a synchronous
 * byte-wide register port and that analog comparators arrive synchronised.
 */
`timescale 1ns/100ps
// Operation
// - Picture-light bit enables a 200 ms limit on the picture light.
// - Torch code above 100 mA forces the 200 ms limit automatically.
// - Thermal enable biases sensor; low level latches and cuts flash current.
// - In-flash check tests LEDs during flash and aborts on a fault.
// - Idle check tests both LEDs outside flashes, results in status.
// - Bits 0 and 1 enable LED1 and LED2 respectively.
// - Soft reset bit clears every writable register to zero; status keeps its latches.
// - Pump-during-flash clear turns the pump off while flashing.
// - Flash select clear means torch mode, no firing, 100 mA cap.
// - Software trigger starts flash unless external enabled; clearing stops it.
// - External trigger has priority over the software trigger.
// - External flash follows the pin's high width, time-out armed.
// - External flash drives both enabled LEDs together.
// - Pump activate runs the pump at the programmed voltage; flash allowed.
// - Pre-charge tracks battery when pump idle; only limited flash.
// - Indicator bit enables the indicator function.
// - Flash current fields are six bits; top two read zero.
// - Torch current field is seven bits; top bit reads zero.
// - Delay fields count in 2 ms steps.
// - Width fields count in 1 ms steps.
// - Photo threshold is an eight-bit field used with photo enable.
// - Rising thermal-clear clears the latch; held high pauses monitoring.
// - Status shows charged, thermal-normal, short and open checks, one normal.
// - Flash time-out in 2 ms steps, disabled only by both disable bits.
module flash_led_config
    import flash_led_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       trigger_pin_i,
    input  wire logic       thermal_below_limit_i,
    input  wire logic [1:0] led_open_i,
    input  wire logic [1:0] led_short_i,
    input  wire logic       vout_charged_i,
    output regs_s           cfg_o,
    output logic      [1:0] led_flash_o,
    output logic            torch_on_o,
    output logic      [7:0] torch_level_o,
    output logic            pump_on_o,
    output logic            precharge_on_o,
    output logic            flash_limited_o,
    output logic            indicator_on_o,
    output logic            thermal_bias_on_o,
    output logic            photo_sense_on_o,
    output logic            led_check_on_o
);

    typedef struct packed {
        regs_s       regs;
        logic [31:0] tick_cnt;
        logic        tick;
        logic        trig_prev;
        logic        ext_active;
        logic        sw_prev;
        logic [9:0]  flash_ms;
        logic [7:0]  torch_ms;
        logic        overtemp;
        logic        clr_prev;
        logic [1:0]  open_fault;
        logic [1:0]  short_fault;
        logic        rdy;
        logic [7:0]  rdata;
        logic [1:0]  led_flash;
        logic        torch_on;
        logic [7:0]  torch_level;
        logic        pump_on;
        logic        precharge_on;
        logic        flash_limited;
        logic        indicator_on;
        logic        thermal_bias_on;
        logic        photo_sense_on;
        logic        check_on;
    } top_s;

    top_s       q;
    top_s       n;
    logic [1:0] t_on;
    logic [1:0] t_busy;
    logic [1:0] t_start;
    logic       t_stop;

    // Stores one write, keeping only the bits that exist in each register.
    function automatic regs_s reg_write(regs_s r, logic [7:0] a, logic [7:0] d);
        regs_s w;
        w = r;
        if (a == OFS_FEATURE) begin
            w.feature = d;
        end else if (a == OFS_MODE) begin
            w.mode = d & MASK_MODE;
        end else if (a == OFS_FLASH1_CUR) begin
            w.flash1_current = d & MASK_FLASH_CUR;
        end else if (a == OFS_FLASH2_CUR) begin
            w.flash2_current = d & MASK_FLASH_CUR;
        end else if (a == OFS_TORCH_CUR) begin
            w.torch_current = d & MASK_TORCH_CUR;
        end else if (a == OFS_DELAY1) begin
            w.flash1_delay = d;
        end else if (a == OFS_DELAY2) begin
            w.flash2_delay = d;
        end else if (a == OFS_WIDTH1) begin
            w.flash1_width = d;
        end else if (a == OFS_WIDTH2) begin
            w.flash2_width = d;
        end else if (a == OFS_PHOTO_THR) begin
            w.photo_threshold = d;
        end else if (a == OFS_PHOTO_GAIN) begin
            w.photo_gain = d & MASK_PHOTO_GAIN;
        end else if (a == OFS_VOUT_SEL) begin
            w.output_voltage_select = d & MASK_VOUT_SEL;
        end else if (a == OFS_IND_CUR) begin
            w.indicator_current = d & MASK_IND_CUR;
        end else if (a == OFS_THERM_LOW) begin
            w.thermal_low_limit = d & MASK_THERM_LOW;
        end else if (a == OFS_THERM_BIAS) begin
            w.thermal_bias_current = d & MASK_THERM_BIAS;
        end else if (a == OFS_RECHARGE) begin
            w.recharge = d & MASK_RECHARGE;
        end else if (a == OFS_TIMEOUT) begin
            w.timeout = d;
        end
        return w;
    endfunction

    // Read mux; unmapped offsets read as zero.
    function automatic logic [7:0] reg_read(top_s s, logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == OFS_FEATURE) begin
            v = s.regs.feature;
        end else if (a == OFS_MODE) begin
            v = s.regs.mode;
        end else if (a == OFS_FLASH1_CUR) begin
            v = s.regs.flash1_current;
        end else if (a == OFS_FLASH2_CUR) begin
            v = s.regs.flash2_current;
        end else if (a == OFS_TORCH_CUR) begin
            v = s.regs.torch_current;
        end else if (a == OFS_DELAY1) begin
            v = s.regs.flash1_delay;
        end else if (a == OFS_DELAY2) begin
            v = s.regs.flash2_delay;
        end else if (a == OFS_WIDTH1) begin
            v = s.regs.flash1_width;
        end else if (a == OFS_WIDTH2) begin
            v = s.regs.flash2_width;
        end else if (a == OFS_PHOTO_THR) begin
            v = s.regs.photo_threshold;
        end else if (a == OFS_PHOTO_GAIN) begin
            v = s.regs.photo_gain;
        end else if (a == OFS_VOUT_SEL) begin
            v = s.regs.output_voltage_select;
        end else if (a == OFS_IND_CUR) begin
            v = s.regs.indicator_current;
        end else if (a == OFS_THERM_LOW) begin
            v = s.regs.thermal_low_limit;
        end else if (a == OFS_THERM_BIAS) begin
            v = s.regs.thermal_bias_current;
        end else if (a == OFS_RECHARGE) begin
            v = s.regs.recharge;
        end else if (a == OFS_TIMEOUT) begin
            v = s.regs.timeout;
        end else if (a == OFS_STATUS) begin
            v = {s.rdy, ~s.overtemp, 1'b0, ~s.short_fault, 1'b0, ~s.open_fault};
        end
        return v;
    endfunction

    logic       led1_en;
    logic       led2_en;
    logic       ext_en;
    logic       sw_trig;
    logic       thermal_ok;
    logic       flash_allowed;
    logic       flashing;
    logic       soft_reset;
    logic       sw_start;
    logic       sw_stop;
    logic       ext_start;
    logic       fault_now;
    logic       fault_abort;
    logic       timeout_dis;
    logic       timeout_hit;
    logic       abort;
    logic       torch_req;
    logic       torch_limited;
    logic       clr_rise;
    logic [9:0] timeout_ms;

    always_comb begin
        n          = q;
        n.tick     = 1'b0;
        led1_en    = q.regs.feature[B_LED1_EN];
        led2_en    = q.regs.feature[B_LED2_EN];
        ext_en     = q.regs.mode[B_EXT_TRIG_EN];
        sw_trig    = q.regs.mode[B_SW_TRIGGER];
        thermal_ok = !q.overtemp;
        soft_reset = reg_wr_i && (reg_addr_i == OFS_MODE) && reg_wdata_i[B_SOFT_RESET];

        // Millisecond tick shared by every timed function.
        if (q.tick_cnt >= 32'(MS_TICK_CYCLES - 1)) begin
            n.tick_cnt = 32'h0;
            n.tick     = 1'b1;
        end else begin
            n.tick_cnt = q.tick_cnt + 32'h1;
        end

        // Firing needs flash mode, a powered output and no thermal latch.
        flash_allowed = q.regs.mode[B_FLASH_SEL] && thermal_ok
                        && (q.regs.mode[B_PUMP_ACT] || q.regs.mode[B_PRECHARGE_EN]);
        flashing  = q.ext_active || (|t_busy);
        ext_start = ext_en && trigger_pin_i && !q.trig_prev && flash_allowed;
        sw_start  = sw_trig && !q.sw_prev && !ext_en && flash_allowed;
        sw_stop   = !sw_trig && q.sw_prev;

        // Faults only abort while a pulse is actually conducting.
        fault_now   = |({led_open_i, led_short_i} & {t_on | q.led_flash, t_on | q.led_flash});
        fault_abort = q.regs.feature[B_FLASH_CHECK] && fault_now;

        timeout_dis = q.regs.recharge[B_TO_DIS1] && q.regs.recharge[B_TO_DIS2];
        timeout_ms  = 10'(32'(q.regs.timeout) * TIMEOUT_STEP_MS);
        timeout_hit = flashing && !timeout_dis && (q.flash_ms >= timeout_ms);
        abort       = timeout_hit || fault_abort || !flash_allowed || soft_reset;

        if (flashing && q.tick) begin
            n.flash_ms = q.flash_ms + 10'h001;
        end else if (!flashing) begin
            n.flash_ms = 10'h000;
        end

        // External flash lasts as long as the pin stays high.
        if (ext_start) begin
            n.ext_active = 1'b1;
        end else if (!trigger_pin_i || !ext_en || abort) begin
            n.ext_active = 1'b0;
        end
        n.trig_prev = trigger_pin_i;
        n.sw_prev   = sw_trig;

        t_start = {sw_start && led2_en, sw_start && led1_en};
        t_stop  = abort || sw_stop || ext_start;

        n.led_flash[0] = led1_en && !abort && (q.ext_active || t_on[0]);
        n.led_flash[1] = led2_en && !abort && (q.ext_active || t_on[1]);

        // Torch mode: the drive is capped, but the time-out follows the code.
        torch_req = !q.regs.mode[B_FLASH_SEL] && !q.regs.mode[B_INDICATOR_EN]
                    && (led1_en || led2_en) && thermal_ok && q.regs.mode[B_PUMP_ACT];
        torch_limited = q.regs.feature[B_PICTURE_TO]
                        || (q.regs.torch_current > TORCH_LIMIT_CODE);
        if (!torch_req || !torch_limited) begin
            n.torch_ms = 8'h00;
        end else if (q.tick && (q.torch_ms < 8'(PICTURE_TIMEOUT_MS))) begin
            n.torch_ms = q.torch_ms + 8'h01;
        end
        n.torch_on    = torch_req && !(torch_limited
                        && (q.torch_ms >= 8'(PICTURE_TIMEOUT_MS)));
        n.torch_level = (q.regs.torch_current > TORCH_LIMIT_CODE) ?
                        TORCH_LIMIT_CODE : q.regs.torch_current;

        n.pump_on = q.regs.mode[B_PUMP_ACT] && thermal_ok
                    && !(flashing && !q.regs.mode[B_PUMP_FLASH]);
        n.precharge_on  = q.regs.mode[B_PRECHARGE_EN] && !n.pump_on;
        n.flash_limited = q.regs.mode[B_PRECHARGE_EN] && !q.regs.mode[B_PUMP_ACT];
        n.indicator_on  = q.regs.mode[B_INDICATOR_EN];
        n.thermal_bias_on = q.regs.feature[B_THERM_EN];
        n.photo_sense_on  = q.regs.feature[B_PHOTO_EN];

        // A clear wins over a new over-temperature event in the same cycle.
        clr_rise   = q.regs.thermal_low_limit[B_THERM_CLEAR] && !q.clr_prev;
        n.clr_prev = q.regs.thermal_low_limit[B_THERM_CLEAR];
        n.overtemp = (q.overtemp && !clr_rise)
                     || (q.regs.feature[B_THERM_EN] && thermal_below_limit_i
                         && !q.regs.thermal_low_limit[B_THERM_CLEAR]);

        n.check_on = (q.regs.feature[B_IDLE_CHECK] && !flashing)
                     || (q.regs.feature[B_FLASH_CHECK] && flashing);
        if (q.check_on) begin
            n.open_fault  = led_open_i;
            n.short_fault = led_short_i;
        end
        n.rdy = vout_charged_i;

        if (soft_reset) begin
            n.regs = '0;
        end else if (reg_wr_i) begin
            n.regs = reg_write(q.regs, reg_addr_i, reg_wdata_i);
        end
        if (reg_rd_i) begin
            n.rdata = reg_read(q, reg_addr_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q              <= '0;
            q.regs.timeout <= RESET_TIMEOUT;
        end else begin
            q <= n;
        end
    end

    flash_led_timer u_timer1 (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .start_i (t_start[0]),
        .stop_i  (t_stop),
        .tick_i  (q.tick),
        .delay_i (q.regs.flash1_delay),
        .width_i (q.regs.flash1_width),
        .on_o    (t_on[0]),
        .busy_o  (t_busy[0])
    );

    flash_led_timer u_timer2 (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .start_i (t_start[1]),
        .stop_i  (t_stop),
        .tick_i  (q.tick),
        .delay_i (q.regs.flash2_delay),
        .width_i (q.regs.flash2_width),
        .on_o    (t_on[1]),
        .busy_o  (t_busy[1])
    );

    assign reg_rdata_o       = q.rdata;
    assign cfg_o             = q.regs;
    assign led_flash_o       = q.led_flash;
    assign torch_on_o        = q.torch_on;
    assign torch_level_o     = q.torch_level;
    assign pump_on_o         = q.pump_on;
    assign precharge_on_o    = q.precharge_on;
    assign flash_limited_o   = q.flash_limited;
    assign indicator_on_o    = q.indicator_on;
    assign thermal_bias_on_o = q.thermal_bias_on;
    assign photo_sense_on_o  = q.photo_sense_on;
    assign led_check_on_o    = q.check_on;

endmodule

/* File: common/flash_led_pkg.sv */
/*
 * Shared constants and types of the flash LED configuration register bank:
 * register offsets, field positions, masks, reset values, timing constants,
 * the register image and the state records of the flash timers.
 * Assumes a single 20 MHz clock and a synchronous register port.
 */
package flash_led_pkg;

    // Clock rate and the internal millisecond tick.
    localparam int CLK_HZ           = 20_000_000;
    localparam int TICK_PERIOD_MS   = 1;
    localparam int MS_CYCLES        = CLK_HZ / 1000 * TICK_PERIOD_MS;

    // Durations counted in millisecond ticks.
    localparam int PICTURE_TIMEOUT_MS = 200;
    localparam int DELAY_STEP_MS      = 2;
    localparam int WIDTH_STEP_MS      = 1;
    localparam int TIMEOUT_STEP_MS    = 2;

    // Torch current limits.
    localparam int       TORCH_LIMIT_MA   = 100;
    localparam int       TORCH_STEP_MA    = 2;
    localparam bit [7:0] TORCH_LIMIT_CODE = 8'(TORCH_LIMIT_MA / TORCH_STEP_MA);

    // Register offsets.
    localparam bit [7:0] OFS_FEATURE    = 8'h01;
    localparam bit [7:0] OFS_MODE       = 8'h02;
    localparam bit [7:0] OFS_FLASH1_CUR = 8'h03;
    localparam bit [7:0] OFS_FLASH2_CUR = 8'h04;
    localparam bit [7:0] OFS_TORCH_CUR  = 8'h06;
    localparam bit [7:0] OFS_DELAY1     = 8'h07;
    localparam bit [7:0] OFS_DELAY2     = 8'h08;
    localparam bit [7:0] OFS_WIDTH1     = 8'h0a;
    localparam bit [7:0] OFS_WIDTH2     = 8'h0b;
    localparam bit [7:0] OFS_PHOTO_THR  = 8'h0d;
    localparam bit [7:0] OFS_PHOTO_GAIN = 8'h0e;
    localparam bit [7:0] OFS_VOUT_SEL   = 8'h0f;
    localparam bit [7:0] OFS_IND_CUR    = 8'h10;
    localparam bit [7:0] OFS_THERM_LOW  = 8'h11;
    localparam bit [7:0] OFS_THERM_BIAS = 8'h12;
    localparam bit [7:0] OFS_RECHARGE   = 8'h13;
    localparam bit [7:0] OFS_TIMEOUT    = 8'h14;
    localparam bit [7:0] OFS_STATUS     = 8'h17;

    // Writable bits of each register; the rest read as zero.
    localparam bit [7:0] MASK_MODE       = 8'h7f;
    localparam bit [7:0] MASK_FLASH_CUR  = 8'h3f;
    localparam bit [7:0] MASK_TORCH_CUR  = 8'h7f;
    localparam bit [7:0] MASK_PHOTO_GAIN = 8'h7f;
    localparam bit [7:0] MASK_VOUT_SEL   = 8'h07;
    localparam bit [7:0] MASK_IND_CUR    = 8'h3f;
    localparam bit [7:0] MASK_THERM_LOW  = 8'h9f;
    localparam bit [7:0] MASK_THERM_BIAS = 8'h3f;
    localparam bit [7:0] MASK_RECHARGE   = 8'hc7;

    // Field positions of the feature register.
    localparam int B_LED1_EN      = 0;
    localparam int B_LED2_EN      = 1;
    localparam int B_IDLE_CHECK   = 2;
    localparam int B_FLASH_CHECK  = 3;
    localparam int B_PHOTO_EN     = 4;
    localparam int B_RECHARGE_SEL = 5;
    localparam int B_THERM_EN     = 6;
    localparam int B_PICTURE_TO   = 7;

    // Field positions of the mode register.
    localparam int B_INDICATOR_EN = 0;
    localparam int B_PRECHARGE_EN = 1;
    localparam int B_PUMP_ACT     = 2;
    localparam int B_EXT_TRIG_EN  = 3;
    localparam int B_SW_TRIGGER   = 4;
    localparam int B_FLASH_SEL    = 5;
    localparam int B_PUMP_FLASH   = 6;
    localparam int B_SOFT_RESET   = 7;

    // Other field positions.
    localparam int B_THERM_CLEAR  = 7;
    localparam int B_TO_DIS1      = 6;
    localparam int B_TO_DIS2      = 7;

    // Reset values.
    localparam bit [7:0] RESET_ZERO    = 8'h00;
    localparam bit [7:0] RESET_TIMEOUT = 8'h19;

    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] mode;
        logic [7:0] flash1_current;
        logic [7:0] flash2_current;
        logic [7:0] torch_current;
        logic [7:0] flash1_delay;
        logic [7:0] flash2_delay;
        logic [7:0] flash1_width;
        logic [7:0] flash2_width;
        logic [7:0] photo_threshold;
        logic [7:0] photo_gain;
        logic [7:0] output_voltage_select;
        logic [7:0] indicator_current;
        logic [7:0] thermal_low_limit;
        logic [7:0] thermal_bias_current;
        logic [7:0] recharge;
        logic [7:0] timeout;
    } regs_s;

    typedef enum logic [1:0] {
        T_IDLE,
        T_DELAY,
        T_ON
    } timer_state_e;

    typedef struct packed {
        timer_state_e st;
        logic [9:0]   cnt;
        logic         on;
        logic         busy;
    } timer_s;

endpackage

/* File: hdl/flash_led_timer.sv */
/*
 * Per-LED flash sequencer: waits the programmed delay, conducts for the
 * programmed width, then turns off. Assumes a one-cycle millisecond tick.
 */
`timescale 1ns/100ps
module flash_led_timer
    import flash_led_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       start_i,
    input  wire logic       stop_i,
    input  wire logic       tick_i,
    input  wire logic [7:0] delay_i,
    input  wire logic [7:0] width_i,
    output logic            on_o,
    output logic            busy_o
);

    timer_s s_q;
    timer_s s_d;

    // Phases advance on the shared tick, so each phase may run up to one
    // tick short; this keeps one prescaler for both LEDs.
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            T_IDLE: begin
                if (start_i) begin
                    if (delay_i != 8'h00) begin
                        s_d.st  = T_DELAY;
                        s_d.cnt = 10'(32'(delay_i) * DELAY_STEP_MS);
                    end else if (width_i != 8'h00) begin
                        s_d.st  = T_ON;
                        s_d.cnt = 10'(32'(width_i) * WIDTH_STEP_MS);
                    end
                end
            end
            T_DELAY: begin
                if (tick_i) begin
                    if (s_q.cnt == 10'h001) begin
                        s_d.st  = (width_i != 8'h00) ? T_ON : T_IDLE;
                        s_d.cnt = 10'(32'(width_i) * WIDTH_STEP_MS);
                    end else begin
                        s_d.cnt = s_q.cnt - 10'h001;
                    end
                end
            end
            T_ON: begin
                if (tick_i) begin
                    if (s_q.cnt == 10'h001) begin
                        s_d.st  = T_IDLE;
                        s_d.cnt = 10'h000;
                    end else begin
                        s_d.cnt = s_q.cnt - 10'h001;
                    end
                end
            end
            default: begin
                s_d.st = T_IDLE;
            end
        endcase
        if (stop_i) begin
            s_d.st  = T_IDLE;
            s_d.cnt = 10'h000;
        end
        s_d.on   = (s_d.st == T_ON);
        s_d.busy = (s_d.st != T_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign on_o   = s_q.on;
    assign busy_o = s_q.busy;

endmodule

/* File: dv/flash_led_config_monitor.sv */
/* Port checker for the flash LED register bank.
   Assumes one clock and binding to flash_led_config. */
`timescale 1ns/100ps
module flash_led_config_monitor
    import flash_led_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       trigger_pin_i,
    input wire regs_s      cfg_o,
    input wire logic [1:0] led_flash_o,
    input wire logic [7:0] torch_level_o,
    input wire logic       pump_on_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_soft_reset: assert property (reg_wr_i && reg_addr_i == 8'h02 && reg_wdata_i[7]
        |=> cfg_o == '0) else $error("soft reset left a register set");
    chk_flash_mask: assert property (
        cfg_o.flash1_current[7:6] == 2'b00 && cfg_o.flash2_current[7:6] == 2'b00)
        else $error("flash current top bits set");
    chk_torch_mask: assert property (cfg_o.torch_current[7] == 1'b0)
        else $error("torch current top bit set");
    chk_torch_cap: assert property (torch_level_o <= 8'h32)
        else $error("torch level above cap");
    chk_fire_mode: assert property ($rose(|led_flash_o) |-> cfg_o.mode[5])
        else $error("flash fired in torch mode");
    chk_led2_gate: assert property ($rose(led_flash_o[1]) |-> cfg_o.feature[1])
        else $error("disabled LED fired");
    chk_ext_start: assert property ($rose(trigger_pin_i) && cfg_o.mode[3] && cfg_o.mode[5]
        && cfg_o.mode[2] && cfg_o.timeout != 8'h00 |-> ##2 led_flash_o == cfg_o.feature[1:0])
        else $error("pin edge did not fire enabled LEDs");
    chk_ext_end: assert property ($fell(trigger_pin_i) && cfg_o.mode[3]
        |-> ##2 led_flash_o == 2'b00) else $error("flash outlived the pin pulse");
    chk_pump_off: assert property (|led_flash_o && $past(|led_flash_o) && !cfg_o.mode[6]
        |-> !pump_on_o) else $error("pump ran during flash");
endmodule
bind flash_led_config flash_led_config_monitor u_mon (.clk_i, .reset_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i, .trigger_pin_i, .cfg_o, .led_flash_o, .torch_level_o, .pump_on_o);

/* File: dv/flash_trigger_source.sv */
/* External flash trigger source.
   Assumes it is driven on the falling clock edge. */
`timescale 1ns/100ps
module flash_trigger_source (
    input  wire logic clk_i,
    output logic      trigger_pin_o
);
    initial trigger_pin_o = 1'b0;
    task automatic pulse(input int w);
        @(negedge clk_i) trigger_pin_o = 1'b1;
        repeat (w) @(negedge clk_i);
        trigger_pin_o = 1'b0;
    endtask
endmodule

/* File: dv/tb_flash_led_config.sv */
/* Self-checking bench of the flash LED register bank.
   Assumes the trigger source model and the bound checker. */
`timescale 1ns/100ps
module tb_flash_led_config;
    import flash_led_pkg::*;
    logic       clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_d = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, torch_level_o, d;
    logic       trigger_pin_i, pump_on_o;
    logic       thermal_below_limit_i = 1'b0, vout_charged_i = 1'b1;
    logic [1:0] led_flash_o, led_open_i = 2'b00, led_short_i = 2'b00;
    regs_s      cfg_o;
    logic [7:0] exp_q[$];
    int         n_errors = 0, n_checks = 0;
    bit   [7:0] adr[15] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b,
                            8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h05};
    bit   [7:0] msk[15] = '{8'hff, 8'h3f, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff,
                            8'hff, 8'h7f, 8'h07, 8'h3f, 8'h9f, 8'h3f, 8'h00};
    flash_led_config #(.MS_TICK_CYCLES(20)) u_dut (.clk_i, .reset_i, .reg_wr_i, .reg_rd_i,
        .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .trigger_pin_i, .thermal_below_limit_i,
        .led_open_i, .led_short_i, .vout_charged_i, .cfg_o, .led_flash_o,
        .torch_on_o(), .torch_level_o, .pump_on_o, .precharge_on_o(), .flash_limited_o(),
        .indicator_on_o(), .thermal_bias_on_o(), .photo_sense_on_o(), .led_check_on_o());
    flash_trigger_source u_src (.clk_i, .trigger_pin_o(trigger_pin_i));
    always #25 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, v};
        @(negedge clk_i) reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i) {reg_rd_i, reg_addr_i} = {1'b1, a};
        exp_q.push_back(e);
        @(negedge clk_i) reg_rd_i = 1'b0;
    endtask
    task automatic led_is(input int n, input logic [1:0] e);
        repeat (n) @(negedge clk_i);
        chk({6'h00, led_flash_o}, {6'h00, e});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Read data lands one edge after the strobe, so the oldest note is compared then.
    always @(posedge clk_i) rd_d <= reg_rd_i;
    always @(negedge clk_i) if (rd_d) chk(reg_rdata_o, exp_q.pop_front());
    initial begin
        #1000000;
        n_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(7));
        repeat (3) @(negedge clk_i);
        reset_i = 1'b0;
        for (int i = 0; i < 15; i++) begin
            d = 8'($urandom);
            rd(adr[i], 8'h00);
            wr(adr[i], d);
            rd(adr[i], d & msk[i]);
        end
        $display("register test done");
        wr(8'h01, 8'h03);
        wr(8'h02, 8'h2c);
        u_src.pulse(10);
        led_is(0, 2'b11);
        led_is(3, 2'b00);
        wr(8'h02, 8'h3c);
        led_is(60, 2'b00);
        $display("trigger test done");
        wr(8'h07, 8'h01);
        wr(8'h0a, 8'h04);
        wr(8'h01, 8'h01);
        wr(8'h02, 8'h24);
        wr(8'h02, 8'h34);
        led_is(15, 2'b00);
        led_is(35, 2'b01);
        led_is(90, 2'b00);
        wr(8'h02, 8'h24);
        wr(8'h02, 8'h34);
        led_is(50, 2'b01);
        wr(8'h02, 8'h24);
        led_is(3, 2'b00);
        $display("software flash test done");
        wr(8'h02, 8'h80);
        rd(8'h01, 8'h00);
        rd(8'h14, 8'h00);
        repeat (2) @(negedge clk_i);
        $display("soft reset test done");
        {thermal_below_limit_i, led_open_i, led_short_i, vout_charged_i} = 6'b1_10_01_0;
        wr(8'h01, 8'h44);
        @(negedge clk_i);
        rd(8'h17, 8'h11);
        {thermal_below_limit_i, led_open_i, led_short_i, vout_charged_i} = 6'b0_00_00_1;
        rd(8'h17, 8'h9b);
        wr(8'h11, 8'h80);
        wr(8'h11, 8'h00);
        rd(8'h17, 8'hdb);
        $display("thermal and status test done");
        @(negedge clk_i) reset_i = 1'b1;
        @(negedge clk_i) reset_i = 1'b0;
        rd(8'h14, RESET_TIMEOUT);
        @(negedge clk_i);
        $display("reset test done");
        wrap_up();
    end
endmodule
